/* File: design/fault_diag_pkg.sv */
package fault_diag_pkg;

  // Sizes of the monitored inputs.
  localparam int NumCells = 12;
  localparam int NumWires = 13;
  localparam int NumTemps = 4;
  localparam int CodeW = 14;
  localparam int SumW = 16;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] AddrSummary = 8'h00;
  localparam logic [7:0] AddrOvDetail = 8'h04;
  localparam logic [7:0] AddrUvDetail = 8'h08;
  localparam logic [7:0] AddrWireDetail = 8'h0C;
  localparam logic [7:0] AddrTempDetail = 8'h10;
  localparam logic [7:0] AddrFaultSetup = 8'h14;
  localparam logic [7:0] AddrCellSetup = 8'h18;
  localparam logic [7:0] AddrDevSetup = 8'h1C;
  localparam logic [7:0] AddrOvLimit = 8'h20;
  localparam logic [7:0] AddrUvLimit = 8'h24;
  localparam logic [7:0] AddrTempLimit = 8'h28;
  localparam logic [7:0] AddrCommand = 8'h2C;
  localparam logic [7:0] AddrStatus = 8'h30;

  // Bit positions in the fault summary register.
  localparam int SumOv = 0;
  localparam int SumUv = 1;
  localparam int SumWire = 2;
  localparam int SumTemp = 3;
  localparam int SumSupply = 4;
  localparam int SumGround = 5;
  localparam int SumClock = 6;
  localparam int SumChecksum = 7;
  localparam int SumBits = 8;

  // Field positions in setup and command registers.
  localparam int FiltSelLsb = 0;
  localparam int TempEnLsb = 4;
  localparam int WireCurBit = 0;
  localparam int CmdCalcBit = 0;
  localparam int CmdCheckBit = 1;
  localparam int CmdWakeBit = 2;

  // Reset values; the cell scale puts 5 V at the top code, temperature 2.5 V.
  localparam logic [2:0] FiltSelRst = 3'h3;
  localparam logic [13:0] CellFullScale = 14'h1FFF;
  localparam logic [13:0] TempFullScale = 14'h3FFF;
  localparam logic [13:0] LimitZero = 14'h0000;

  typedef struct packed {
    logic [2:0] filterSel;
    logic [NumTemps-1:0] tempTestEn;
    logic [NumCells-1:0] cellAbsent;
    logic wireCurrentHigh;
    logic [CodeW-1:0] ovLimit;
    logic [CodeW-1:0] uvLimit;
    logic [CodeW-1:0] tempLimit;
  } cfg_s;

  typedef struct packed {
    logic [NumCells-1:0][CodeW-1:0] cellCode;
    logic [NumTemps-1:0][CodeW-1:0] tempCode;
    logic [NumWires-1:0] openWire;
    logic supplyOpen;
    logic groundOpen;
  } meas_s;

  typedef enum logic [2:0] {
    CkIdle = 3'h1,
    CkCalc = 3'h2,
    CkCheck = 3'h4
  } cksum_state_e;

endpackage : fault_diag_pkg

/* File: design/fault_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module fault_filter #(
  parameter int CntW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sample,
  input wire logic result,
  input wire logic [2:0] sel,
  output logic hit
);

  logic [CntW-1:0] count_q;
  logic [CntW:0] next;
  logic [CntW:0] target;

  // The run length is two to the power of the select code.
  assign target = (CntW+1)'(1) << sel;
  assign next = {1'b0, count_q} + (CntW+1)'(1);
  assign hit = sample & result & ~clear & (next >= target);

  // A negative sample or a select change empties the run; saturate on overflow.
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_q <= '0;
    end else if (sample) begin
      if (!result) begin
        count_q <= '0;
      end else if (!next[CntW]) begin
        count_q <= next[CntW-1:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_negReset;
    sample && !result && !clear |=> count_q == '0;
  endproperty
  a_negReset: assert property (p_negReset) else $error("Negative sample kept run.");

  property p_clear;
    clear |=> count_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Filter not cleared.");

  property p_hitLen;
    hit |-> {1'b0, count_q} + (CntW+1)'(1) >= ((CntW+1)'(1) << sel);
  endproperty
  a_hitLen: assert property (p_hitLen) else $error("Fault before full run.");

endmodule : fault_filter
`default_nettype wire

/* File: design/config_checksum.sv */
`timescale 1ns/10ps
`default_nettype none
module config_checksum #(
  parameter int DataW = 62,
  parameter int SumW = 16
) (
  input wire logic [DataW-1:0] data,
  output logic [SumW-1:0] sum
);

  localparam int Words = (DataW + SumW - 1) / SumW;

  logic [Words*SumW-1:0] padded;

  assign padded = {{(Words*SumW-DataW){1'b0}}, data};

  // Rotate and fold so that swapped fields still change the result.
  always_comb begin
    sum = '0;
    for (int i = 0; i < Words; i++) begin
      sum = {sum[SumW-2:0], sum[SumW-1]} ^ padded[i*SumW +: SumW];
    end
  end

endmodule : config_checksum
`default_nettype wire

/* File: design/fault_diagnostics_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - Watch internal functions always; each static fault sets its summary bit.
// - Oscillator fault sets clock flag first, then puts device to sleep.
// - Sleeping device ignores normal commands; next device reports comms failure.
// - Cell limits use scale where 14'h1FFF equals 5 V.
// - Filter select resets to 3'b011, eight consecutive samples.
// - Cell-setup bit 1 means absent; absent cells skip voltage checks.
// - Each cell has own OV and UV filters needing consecutive positives.
// - Any negative result zeroes that filter's run count.
// - Changing the filter select field clears every filter.
// - Supply and ground open use same consecutive-run filtering.
// - Fault arriving while summary is zero sends summary unasked.
// - Wire test current select: set gives 1 mA, clear 150 uA.
// - Inputs two to twelve masked by cell setup; lowest two always tested.
// - Temperature limit uses scale where 14'h3FFF equals 2.5 V.
// - Four enable bits choose which temperature inputs are tested.
// - Over-temperature flagged at once when enabled input below limit.
// - Calculate command stores checksum of configuration registers.
// - Check command recomputes, compares, sets checksum flag on mismatch.
// - Checksum fault halts scanning and cell balancing.
// - Voltage scan end samples all four; single measure checks OV, UV.
// - Run length is two to the select code, 1 to 128.
module fault_diagnostics_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fault_diag_pkg::meas_s meas,
  input wire logic voltScanDone,
  input wire logic cellMeasureDone,
  input wire logic [3:0] cellMeasureIdx,
  input wire logic wireScanDone,
  input wire logic tempScanDone,
  input wire logic oscFault,
  output logic sleepMode,
  output logic haltActivity,
  output logic wireTestCurrentHigh,
  output logic summaryTxValid,
  output logic [7:0] summaryTxData
);

  localparam int NC = fault_diag_pkg::NumCells;
  localparam int NW = fault_diag_pkg::NumWires;
  localparam int NT = fault_diag_pkg::NumTemps;
  localparam int NF = 2 * NC + 2;
  localparam int SB = fault_diag_pkg::SumBits;

  fault_diag_pkg::cfg_s cfg_q;
  fault_diag_pkg::cksum_state_e ckState_q;
  logic [SB-1:0] summary_q, summary_d, sumSet, sumClr;
  logic [NC-1:0] ovDetail_q, uvDetail_q, ovSet, uvSet;
  logic [NW-1:0] wireDetail_q, wireSet, wireMask;
  logic [NT-1:0] tempDetail_q, tempSet;
  logic [NF-1:0] filtSample, filtResult, filtHit;
  logic [2:0] selPrev_q;
  logic [15:0] sumNow, sumStored_q;
  logic access, wrEn, rdEn, mapped, selChange, cksumMiss;
  logic calcCmd, checkCmd, wakeCmd;
  logic [31:0] rdData;

  // APB: one wait state so read data comes from a flop.
  assign access = psel & penable;
  assign wrEn = access & pready & pwrite;
  assign rdEn = access & ~pready;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rdEn;
      pslverr <= rdEn & ~mapped;
      if (rdEn && !pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // Read mux; unmapped addresses read zero and raise pslverr.
  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    case (paddr)
      fault_diag_pkg::AddrSummary: rdData[SB-1:0] = summary_q;
      fault_diag_pkg::AddrOvDetail: rdData[NC-1:0] = ovDetail_q;
      fault_diag_pkg::AddrUvDetail: rdData[NC-1:0] = uvDetail_q;
      fault_diag_pkg::AddrWireDetail: rdData[NW-1:0] = wireDetail_q;
      fault_diag_pkg::AddrTempDetail: rdData[NT-1:0] = tempDetail_q;
      fault_diag_pkg::AddrFaultSetup: begin
        rdData[fault_diag_pkg::FiltSelLsb +: 3] = cfg_q.filterSel;
        rdData[fault_diag_pkg::TempEnLsb +: NT] = cfg_q.tempTestEn;
      end
      fault_diag_pkg::AddrCellSetup: rdData[NC-1:0] = cfg_q.cellAbsent;
      fault_diag_pkg::AddrDevSetup: rdData[fault_diag_pkg::WireCurBit] = cfg_q.wireCurrentHigh;
      fault_diag_pkg::AddrOvLimit: rdData[13:0] = cfg_q.ovLimit;
      fault_diag_pkg::AddrUvLimit: rdData[13:0] = cfg_q.uvLimit;
      fault_diag_pkg::AddrTempLimit: rdData[13:0] = cfg_q.tempLimit;
      fault_diag_pkg::AddrCommand: rdData = 32'h0000_0000;
      fault_diag_pkg::AddrStatus: rdData[2:0] = {ckState_q != fault_diag_pkg::CkIdle,
                                                  haltActivity, sleepMode};
      default: mapped = 1'b0;
    endcase
  end

  // Configuration page; the limits are raw codes on the measurement scale.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.filterSel <= fault_diag_pkg::FiltSelRst;
      cfg_q.tempTestEn <= '0;
      cfg_q.cellAbsent <= '0;
      cfg_q.wireCurrentHigh <= 1'b0;
      cfg_q.ovLimit <= fault_diag_pkg::CellFullScale;
      cfg_q.uvLimit <= fault_diag_pkg::LimitZero;
      cfg_q.tempLimit <= fault_diag_pkg::LimitZero;
    end else if (wrEn) begin
      case (paddr)
        fault_diag_pkg::AddrFaultSetup: begin
          cfg_q.filterSel <= pwdata[fault_diag_pkg::FiltSelLsb +: 3];
          cfg_q.tempTestEn <= pwdata[fault_diag_pkg::TempEnLsb +: NT];
        end
        fault_diag_pkg::AddrCellSetup: cfg_q.cellAbsent <= pwdata[NC-1:0];
        fault_diag_pkg::AddrDevSetup: cfg_q.wireCurrentHigh <= pwdata[fault_diag_pkg::WireCurBit];
        fault_diag_pkg::AddrOvLimit: cfg_q.ovLimit <= pwdata[13:0];
        fault_diag_pkg::AddrUvLimit: cfg_q.uvLimit <= pwdata[13:0];
        fault_diag_pkg::AddrTempLimit: cfg_q.tempLimit <= pwdata[13:0];
        default: ;
      endcase
    end
  end

  // The analog side picks 1 mA or 150 uA from this level.
  always_ff @(posedge clk) begin
    if (rst) begin
      wireTestCurrentHigh <= 1'b0;
    end else begin
      wireTestCurrentHigh <= cfg_q.wireCurrentHigh;
    end
  end

  // A changed select is seen one cycle after the write and clears all filters.
  always_ff @(posedge clk) begin
    if (rst) begin
      selPrev_q <= fault_diag_pkg::FiltSelRst;
    end else begin
      selPrev_q <= cfg_q.filterSel;
    end
  end
  assign selChange = cfg_q.filterSel != selPrev_q;

  // Sample points: scan end for all but absent cells, single measure for its own cell only.
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      filtSample[i] = ~cfg_q.cellAbsent[i] & (voltScanDone |
                      (cellMeasureDone & (cellMeasureIdx == 4'(i))));
      filtSample[i+NC] = filtSample[i];
      filtResult[i] = meas.cellCode[i] > cfg_q.ovLimit;
      filtResult[i+NC] = meas.cellCode[i] < cfg_q.uvLimit;
    end
    filtSample[2*NC] = voltScanDone;
    filtSample[2*NC+1] = voltScanDone;
    filtResult[2*NC] = meas.supplyOpen;
    filtResult[2*NC+1] = meas.groundOpen;
  end

  // One independent filter per cell and direction, plus supply and ground.
  for (genvar g = 0; g < NF; g++) begin : gFilt
    fault_filter #(.CntW(8)) uFilt (
      .clk(clk),
      .rst(rst),
      .clear(selChange),
      .sample(filtSample[g]),
      .result(filtResult[g]),
      .sel(cfg_q.filterSel),
      .hit(filtHit[g])
    );
  end

  assign ovSet = filtHit[NC-1:0];
  assign uvSet = filtHit[2*NC-1:NC];

  // The two lowest inputs are always tested; the rest follow cell setup.
  assign wireMask = {~cfg_q.cellAbsent[NC-1:1], 2'h3};
  assign wireSet = wireScanDone ? (meas.openWire & wireMask) : '0;

  // Temperature faults bypass the filters.
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      tempSet[i] = tempScanDone & cfg_q.tempTestEn[i] &
                   (meas.tempCode[i] < cfg_q.tempLimit);
    end
  end

  // Commands are dropped while asleep, except the wakeup.
  assign calcCmd = wrEn && paddr == fault_diag_pkg::AddrCommand &&
                   pwdata[fault_diag_pkg::CmdCalcBit] && !sleepMode;
  assign checkCmd = wrEn && paddr == fault_diag_pkg::AddrCommand &&
                    pwdata[fault_diag_pkg::CmdCheckBit] && !sleepMode;
  assign wakeCmd = wrEn && paddr == fault_diag_pkg::AddrCommand &&
                   pwdata[fault_diag_pkg::CmdWakeBit];

  config_checksum #(.DataW($bits(fault_diag_pkg::cfg_s)), .SumW(16)) uCksum (
    .data(cfg_q),
    .sum(sumNow)
  );

  // Checksum sequencer; calculate wins if both command bits are written.
  always_ff @(posedge clk) begin
    if (rst) begin
      ckState_q <= fault_diag_pkg::CkIdle;
      sumStored_q <= 16'h0000;
    end else begin
      unique case (ckState_q)
        fault_diag_pkg::CkIdle: begin
          if (calcCmd) begin
            ckState_q <= fault_diag_pkg::CkCalc;
          end else if (checkCmd) begin
            ckState_q <= fault_diag_pkg::CkCheck;
          end
        end
        fault_diag_pkg::CkCalc: begin
          sumStored_q <= sumNow;
          ckState_q <= fault_diag_pkg::CkIdle;
        end
        fault_diag_pkg::CkCheck: ckState_q <= fault_diag_pkg::CkIdle;
        default: ckState_q <= fault_diag_pkg::CkIdle;
      endcase
    end
  end
  assign cksumMiss = ckState_q == fault_diag_pkg::CkCheck && sumNow != sumStored_q;

  // Summary set events; a set in the clearing cycle wins.
  always_comb begin
    sumSet = '0;
    sumSet[fault_diag_pkg::SumOv] = |ovSet;
    sumSet[fault_diag_pkg::SumUv] = |uvSet;
    sumSet[fault_diag_pkg::SumWire] = |wireSet;
    sumSet[fault_diag_pkg::SumTemp] = |tempSet;
    sumSet[fault_diag_pkg::SumSupply] = filtHit[2*NC];
    sumSet[fault_diag_pkg::SumGround] = filtHit[2*NC+1];
    sumSet[fault_diag_pkg::SumClock] = oscFault;
    sumSet[fault_diag_pkg::SumChecksum] = cksumMiss;
    sumClr = (wrEn && paddr == fault_diag_pkg::AddrSummary) ? pwdata[SB-1:0] : '0;
    summary_d = (summary_q & ~sumClr) | sumSet;
  end

  // Sticky flags, cleared only by writing ones.
  always_ff @(posedge clk) begin
    if (rst) begin
      summary_q <= '0;
      ovDetail_q <= '0;
      uvDetail_q <= '0;
      wireDetail_q <= '0;
      tempDetail_q <= '0;
    end else begin
      summary_q <= summary_d;
      ovDetail_q <= (ovDetail_q & ~((wrEn && paddr == fault_diag_pkg::AddrOvDetail) ?
                    pwdata[NC-1:0] : '0)) | ovSet;
      uvDetail_q <= (uvDetail_q & ~((wrEn && paddr == fault_diag_pkg::AddrUvDetail) ?
                    pwdata[NC-1:0] : '0)) | uvSet;
      wireDetail_q <= (wireDetail_q & ~((wrEn && paddr == fault_diag_pkg::AddrWireDetail) ?
                      pwdata[NW-1:0] : '0)) | wireSet;
      tempDetail_q <= (tempDetail_q & ~((wrEn && paddr == fault_diag_pkg::AddrTempDetail) ?
                      pwdata[NT-1:0] : '0)) | tempSet;
    end
  end

  // Unasked report only on the step from an empty summary.
  always_ff @(posedge clk) begin
    if (rst) begin
      summaryTxValid <= 1'b0;
      summaryTxData <= 8'h00;
    end else begin
      summaryTxValid <= (|sumSet) && summary_q == '0;
      summaryTxData <= summary_d;
    end
  end

  // Sleep follows the clock flag by a cycle; a set flag keeps the device asleep until cleared.
  always_ff @(posedge clk) begin
    if (rst) begin
      sleepMode <= 1'b0;
    end else if (summary_q[fault_diag_pkg::SumClock]) begin
      sleepMode <= 1'b1;
    end else if (wakeCmd) begin
      sleepMode <= 1'b0;
    end
  end

  // Scanning and balancing stay halted while the checksum flag is set.
  always_ff @(posedge clk) begin
    if (rst) begin
      haltActivity <= 1'b0;
    end else begin
      haltActivity <= summary_d[fault_diag_pkg::SumChecksum];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_checkCmd;
    checkCmd && ckState_q == fault_diag_pkg::CkIdle && !calcCmd;
  endsequence

  property p_sleepAfterFlag;
    $rose(sleepMode) |-> $past(summary_q[fault_diag_pkg::SumClock]);
  endproperty
  a_sleepAfterFlag: assert property (p_sleepAfterFlag) else $error("Slept before flag.");

  property p_oscFlag;
    oscFault |=> summary_q[fault_diag_pkg::SumClock] ##1 (sleepMode || wakeCmd);
  endproperty
  a_oscFlag: assert property (p_oscFlag) else $error("Clock fault not handled.");

  property p_txOnEmpty;
    summaryTxValid |-> $past(summary_q) == '0 && summaryTxData != '0;
  endproperty
  a_txOnEmpty: assert property (p_txOnEmpty) else $error("Bad unasked report.");

  property p_absentSkip;
    (ovDetail_q & ~$past(ovDetail_q) & $past(cfg_q.cellAbsent)) == '0;
  endproperty
  a_absentSkip: assert property (p_absentSkip) else $error("Absent cell flagged.");

  property p_overTemp;
    tempScanDone && cfg_q.tempTestEn[0] && meas.tempCode[0] < cfg_q.tempLimit
      |=> tempDetail_q[0] && summary_q[fault_diag_pkg::SumTemp];
  endproperty
  a_overTemp: assert property (p_overTemp) else $error("Over-temp missed.");

  property p_checkFlag;
    s_checkCmd ##1 (sumNow != sumStored_q) |=> summary_q[fault_diag_pkg::SumChecksum];
  endproperty
  a_checkFlag: assert property (p_checkFlag) else $error("Checksum miss lost.");

  property p_halt;
    summary_q[fault_diag_pkg::SumChecksum] |-> haltActivity;
  endproperty
  a_halt: assert property (p_halt) else $error("Activity not halted.");

  property p_sticky;
    ovDetail_q[0] && !(wrEn && paddr == fault_diag_pkg::AddrOvDetail) |=> ovDetail_q[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Detail flag dropped.");

  property p_defaultSel;
    $fell(rst) |-> cfg_q.filterSel == fault_diag_pkg::FiltSelRst;
  endproperty
  a_defaultSel: assert property (p_defaultSel) else $error("Wrong select reset.");

endmodule : fault_diagnostics_monitor
`default_nettype wire

/* File: verif/front_end_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the scan engine and oscillator monitor. The bench sets the
// measured levels, then asks for one done pulse, which stands for one cycle.
module front_end_model (
  input wire logic clk,
  output var fault_diag_pkg::meas_s meas,
  output logic voltScanDone,
  output logic cellMeasureDone,
  output logic [3:0] cellMeasureIdx,
  output logic wireScanDone,
  output logic tempScanDone,
  output logic oscFault
);
  // Quiet levels: cells mid-scale, temperature inputs above every limit used.
  initial begin
    meas = '0;
    for (int i = 0; i < fault_diag_pkg::NumCells; i++) meas.cellCode[i] = 14'h1000;
    for (int i = 0; i < fault_diag_pkg::NumTemps; i++) meas.tempCode[i] = 14'h3000;
    {voltScanDone, cellMeasureDone, wireScanDone, tempScanDone, oscFault} = '0;
    cellMeasureIdx = 4'h0;
  end

  // The trailing edge lets the result land and keeps a re-entry off the same step.
  task automatic scan(input int k, input logic [3:0] i);
    @(posedge clk);
    case (k)
      0: voltScanDone <= 1'b1;
      1: begin
        cellMeasureDone <= 1'b1;
        cellMeasureIdx <= i;
      end
      2: wireScanDone <= 1'b1;
      default: tempScanDone <= 1'b1;
    endcase
    @(posedge clk);
    {voltScanDone, cellMeasureDone, wireScanDone, tempScanDone} <= '0;
    @(posedge clk);
  endtask : scan
endmodule : front_end_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ASum = fault_diag_pkg::AddrSummary;
  localparam logic [7:0] ASet = fault_diag_pkg::AddrFaultSetup;
  localparam logic [7:0] ACmd = fault_diag_pkg::AddrCommand;
  localparam logic [7:0] AStat = fault_diag_pkg::AddrStatus;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slvErr;
  logic sleepMode, haltActivity, wireTestCurrentHigh, summaryTxValid;
  logic voltScanDone, cellMeasureDone, wireScanDone, tempScanDone, oscFault;
  logic [3:0] cellMeasureIdx;
  logic [7:0] paddr, summaryTxData, txData;
  logic [31:0] pwdata, prdata, q;
  fault_diag_pkg::meas_s meas;
  int err_count = 0, compares = 0, txCnt = 0;

  fault_diagnostics_monitor uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .voltScanDone(voltScanDone),
    .cellMeasureDone(cellMeasureDone), .cellMeasureIdx(cellMeasureIdx),
    .wireScanDone(wireScanDone), .tempScanDone(tempScanDone), .oscFault(oscFault),
    .sleepMode(sleepMode), .haltActivity(haltActivity),
    .wireTestCurrentHigh(wireTestCurrentHigh), .summaryTxValid(summaryTxValid),
    .summaryTxData(summaryTxData));
  front_end_model fe (.clk(clk), .meas(meas), .voltScanDone(voltScanDone),
    .cellMeasureDone(cellMeasureDone), .cellMeasureIdx(cellMeasureIdx),
    .wireScanDone(wireScanDone), .tempScanDone(tempScanDone), .oscFault(oscFault));

  // A 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count unasked summary transmissions and keep the last value sent.
  always @(posedge clk) if (summaryTxValid === 1'b1) begin
    txCnt <= txCnt + 1;
    txData <= summaryTxData;
  end

  task automatic summarize();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // One APB transfer; pready is sampled at each rising edge, where data is also taken.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      summarize();
    end
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask : rc

  // Main sequence; faults accumulate in the summary from the supply test onward.
  initial begin
    {psel, penable, pwrite} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc("filter sel", ASet, 32'h0000_0003);
    rc("ov limit", 8'h20, 32'h0000_1FFF);
    rc("summary", ASum, 32'h0000_0000);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(slvErr));
    wr(ASet, 32'h0000_0001);
    wr(8'h18, 32'h0000_0002);
    wr(8'h20, 32'h0000_1800);
    fe.meas.cellCode[0] <= 14'h1900;
    fe.meas.cellCode[1] <= 14'h1900;
    fe.scan(0, 4'h0);
    rc("summary", ASum, 32'h0000_0000);
    fe.scan(0, 4'h0);
    rc("ov detail", 8'h04, 32'h0000_0001);
    rc("summary", ASum, 32'h0000_0001);
    chk("tx count", 32'h0000_0001, 32'(txCnt));
    chk("tx data", 32'h0000_0001, 32'(txData));
    fe.meas.cellCode[5] <= 14'h1900;
    fe.scan(1, 4'h5);
    fe.scan(1, 4'h5);
    fe.meas.cellCode[0] <= 14'h1000;
    fe.meas.cellCode[1] <= 14'h1000;
    fe.meas.cellCode[5] <= 14'h1000;
    fe.scan(0, 4'h0);
    rc("ov detail", 8'h04, 32'h0000_0021);
    wr(8'h04, 32'h0000_0021);
    wr(ASum, 32'h0000_0001);
    rc("summary", ASum, 32'h0000_0000);
    wr(8'h24, 32'h0000_0800);
    fe.meas.cellCode[2] <= 14'h0400;
    fe.scan(0, 4'h0);
    fe.meas.cellCode[2] <= 14'h1000;
    fe.scan(0, 4'h0);
    fe.meas.cellCode[2] <= 14'h0400;
    fe.scan(0, 4'h0);
    rc("uv detail", 8'h08, 32'h0000_0000);
    fe.scan(0, 4'h0);
    rc("uv detail", 8'h08, 32'h0000_0004);
    wr(8'h08, 32'h0000_0004);
    wr(ASum, 32'h0000_0002);
    wr(ASet, 32'h0000_0002);
    wr(ASet, 32'h0000_0001);
    fe.scan(0, 4'h0);
    rc("uv detail", 8'h08, 32'h0000_0000);
    fe.meas.cellCode[2] <= 14'h1000;
    {fe.meas.supplyOpen, fe.meas.groundOpen} <= 2'b11;
    fe.scan(0, 4'h0);
    rc("summary", ASum, 32'h0000_0000);
    fe.scan(0, 4'h0);
    rc("summary", ASum, 32'h0000_0030);
    wr(8'h1C, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("wire current", 32'h0000_0001, 32'(wireTestCurrentHigh));
    wr(8'h18, 32'h0000_0003);
    fe.meas.openWire <= 13'h1FFF;
    fe.scan(2, 4'h0);
    rc("wire detail", 8'h0C, 32'h0000_1FFB);
    wr(8'h1C, 32'h0000_0000);
    repeat (2) @(negedge clk);
    chk("wire current", 32'h0000_0000, 32'(wireTestCurrentHigh));
    wr(8'h28, 32'h0000_1000);
    wr(ASet, 32'h0000_0051);
    for (int i = 0; i < fault_diag_pkg::NumTemps; i++) fe.meas.tempCode[i] <= 14'h0800;
    fe.scan(3, 4'h0);
    rc("temp detail", 8'h10, 32'h0000_0005);
    rc("summary", ASum, 32'h0000_003C);
    wr(ACmd, 32'h0000_0001);
    wr(ACmd, 32'h0000_0002);
    rc("status", AStat, 32'h0000_0000);
    wr(8'h20, 32'h0000_1700);
    wr(ACmd, 32'h0000_0002);
    rc("status", AStat, 32'h0000_0002);
    rc("summary", ASum, 32'h0000_00BC);
    wr(8'h20, 32'h0000_1800);
    rc("ov limit", 8'h20, 32'h0000_1800);
    wr(ACmd, 32'h0000_0001);
    fe.oscFault <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("sleep", 32'h0000_0001, 32'(sleepMode));
    rc("summary", ASum, 32'h0000_00FC);
    fe.oscFault <= 1'b0;
    wr(8'h20, 32'h0000_1700);
    wr(ACmd, 32'h0000_0001);
    wr(ASum, 32'h0000_00C0);
    wr(ACmd, 32'h0000_0004);
    rc("status", AStat, 32'h0000_0000);
    wr(ACmd, 32'h0000_0002);
    rc("summary", ASum, 32'h0000_00BC);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
